/* logic/phyrm_pkg.sv */
// Summary of operation
// - led steady on link, blinks on activity
// - led pin may become general purpose io
// - low reset pin starts reset process
// - reset resamples straps, restores all defaults
// - receive dibits valid only with receive valid
// - one output merges carrier and data valid
// - receive error high on bad symbol
// - bad symbol also corrupts delivered receive data
// - master mode drives clock out pin
`default_nettype none
package phyrm_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 25_000_000;  // reference rate
  localparam int unsigned BLINK_NS      = 100_000_000; // blink half period
  localparam longint unsigned BLINK_CYC =
    (longint'(BLINK_NS) * CLK_HZ) / 1_000_000_000;     // rounds down
  localparam int unsigned SLOW_DIV      = 10;          // cycles per dibit
  localparam logic [3:0]  SLOW_LAST     = 4'h9;        // divider top

  // ----------------------------------------------------------------
  // straps and reset values
  // ----------------------------------------------------------------
  localparam int unsigned STRAP_W       = 2;           // strap pins
  localparam int unsigned STRAP_MASTER  = 0;           // master mode bit
  localparam int unsigned STRAP_SETTLE  = 3;           // sync depth
  localparam logic [1:0]  STRAP_RST     = 2'h0;        // default straps

  // ----------------------------------------------------------------
  // receive data layout
  // ----------------------------------------------------------------
  localparam int unsigned BYTE_W        = 8;           // data byte
  localparam int unsigned RXB_W         = 9;           // error + byte
  localparam int unsigned RXB_ERR       = 8;           // error position
  localparam logic [1:0]  ERR_DIBIT     = 2'h1;        // corrupt pattern
  localparam logic [1:0]  LAST_DIBIT    = 2'h3;        // last of byte

  typedef enum logic [0:0] {
    PHYRM_IDLE,
    PHYRM_SEND
  } phyrm_rx_state_e;

endpackage : phyrm_pkg
`default_nettype wire

/* logic/phyrm_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
module phyrm_buffer
  import phyrm_pkg::*;
#(
  parameter int unsigned WIDTH = RXB_W,  // word width
  parameter int unsigned DEPTH = 2       // entries
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("phyrm_buffer depth must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];     // entries
  logic [AW-1:0]    wr_ptr_reg;          // write index
  logic [AW-1:0]    rd_ptr_reg;          // read index
  logic [AW:0]      count_reg;           // occupancy
  logic             push;                // word accepted
  logic             pop;                 // word drained

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];

  // write side
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule // phyrm_buffer
`default_nettype wire

/* logic/phyrm_pin_interface.sv */
`timescale 1ns/1ps
`default_nettype none
module phyrm_pin_interface
  import phyrm_pkg::*;
#(
  parameter longint unsigned BLINK_CYCLES = BLINK_CYC  // blink half period
) (
  input  wire logic               clk,
  input  wire logic               rstn,
  // straps and line state
  input  wire logic [STRAP_W-1:0] strap_pins_in,
  input  wire logic               link_up,
  input  wire logic               speed_100,
  // indicator pin control
  input  wire logic               led_gpio_enable,
  input  wire logic               led_gpio_dir_in,
  input  wire logic               led_gpio_drive_out,
  input  wire logic               link_activity_indicator_in,
  output logic                    link_activity_indicator,
  output logic                    link_activity_indicator_oe_n,
  output logic                    led_gpio_level,
  output logic                    master_mode,
  output logic                    master_clock_output,
  output logic                    master_clock_output_oe_n,
  // decoded receive bytes from the line side
  input  wire logic               rx_carrier,
  input  wire logic [BYTE_W-1:0]  rx_byte_data,
  input  wire logic               rx_byte_error,
  input  wire logic               rx_byte_valid,
  output logic                    rx_byte_ready,
  // receive pins toward the mac
  output logic                    receive_dibit_low,
  output logic                    receive_dibit_high,
  output logic                    receive_valid_flag,
  output logic                    carrier_valid_combined,
  output logic                    receive_error_flag,
  // transmit pins from the mac
  input  wire logic               transmit_dibit_low,
  input  wire logic               transmit_dibit_high,
  input  wire logic               transmit_valid_input,
  output logic [BYTE_W-1:0]       tx_byte_data,
  output logic                    tx_byte_valid
);

  initial begin
    if (BLINK_CYCLES < 2 || BLINK_CYCLES > 64'hFFFF_FFFF)
      $error("phyrm_pin_interface blink period out of range");
  end

  // ----------------------------------------------------------------
  // strap capture after reset release
  // ----------------------------------------------------------------
  logic [STRAP_W-1:0] strap_s1_reg;     // first sync stage
  logic [STRAP_W-1:0] strap_s2_reg;     // second sync stage
  logic [STRAP_W-1:0] strap_s3_reg;     // third sync stage
  logic [STRAP_W-1:0] strap_reg;        // latched straps
  logic [1:0]         settle_reg;       // cycles since release
  logic               strap_done_reg;   // straps latched

  // strap pin synchroniser
  always_ff @(posedge clk) begin
    strap_s1_reg <= strap_pins_in;
    strap_s2_reg <= strap_s1_reg;
    strap_s3_reg <= strap_s2_reg;
  end

  // rescan straps on every reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      strap_reg      <= STRAP_RST;
      settle_reg     <= '0;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      settle_reg <= settle_reg + 1'b1;
      // take the value once the pipe is refilled and stable
      if (settle_reg == 2'(STRAP_SETTLE - 1) &&
          strap_s2_reg == strap_s3_reg) begin
        strap_reg      <= strap_s3_reg;
        strap_done_reg <= 1'b1;
      end else if (settle_reg == 2'(STRAP_SETTLE - 1)) begin
        settle_reg <= settle_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // master clock forwarding
  // ----------------------------------------------------------------
  // reference forwarded as a toggle; slave mode leaves the pin idle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      master_mode              <= 1'b0;
      master_clock_output      <= 1'b0;
      master_clock_output_oe_n <= 1'b1;
    end else begin
      master_mode              <= strap_reg[STRAP_MASTER];
      master_clock_output_oe_n <= !strap_reg[STRAP_MASTER];
      master_clock_output      <= strap_reg[STRAP_MASTER] &&
                                  !master_clock_output;
    end
  end

  // ----------------------------------------------------------------
  // dibit rate divider
  // ----------------------------------------------------------------
  logic [3:0] div_reg;     // slow rate counter
  logic       dibit_en;    // one dibit slot

  // free running divide by ten for 10 Mb/s
  always_ff @(posedge clk) begin
    if (!rstn) begin
      div_reg <= '0;
    end else if (speed_100 || div_reg == SLOW_LAST) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  assign dibit_en = speed_100 || (div_reg == SLOW_LAST);

  // ----------------------------------------------------------------
  // receive buffer and serializer
  // ----------------------------------------------------------------
  logic [RXB_W-1:0] buf_data;        // head word
  logic             buf_valid;       // head present
  logic             buf_pop;         // take head
  logic             buf_in_ready;    // room for a word
  logic             rdy_reg;         // registered ready
  phyrm_rx_state_e  rx_state_reg;    // serializer state
  logic [BYTE_W-1:0] rx_shift_reg;   // byte being sent
  logic             rx_err_reg;      // byte carries error
  logic [1:0]       rx_idx_reg;      // dibit index
  logic             rx_load;         // start a new byte

  phyrm_buffer #(
    .WIDTH (RXB_W),
    .DEPTH (2)
  ) u_rx_buffer (
    .clk       (clk),
    .rstn      (rstn),
    .in_data   ({rx_byte_error, rx_byte_data}),
    .in_valid  (rx_byte_valid && rdy_reg),
    .in_ready  (buf_in_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_pop)
  );

  // ready as a flop; drops one word early so nothing is lost
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdy_reg <= 1'b0;
    end else begin
      rdy_reg <= buf_in_ready && !(rx_byte_valid && rdy_reg &&
                 !buf_pop && buf_valid);
    end
  end

  assign rx_byte_ready = rdy_reg;

  // a new byte starts when idle or after the last dibit
  assign rx_load = dibit_en && buf_valid &&
                   (rx_state_reg == PHYRM_IDLE ||
                    rx_idx_reg == LAST_DIBIT);
  assign buf_pop = rx_load;

  // byte to dibit shifter, low pair first
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_state_reg <= PHYRM_IDLE;
      rx_shift_reg <= '0;
      rx_err_reg   <= 1'b0;
      rx_idx_reg   <= '0;
    end else if (dibit_en) begin
      unique case (rx_state_reg)
        PHYRM_IDLE: begin
          if (rx_load) begin
            rx_state_reg <= PHYRM_SEND;
            rx_shift_reg <= buf_data[BYTE_W-1:0];
            rx_err_reg   <= buf_data[RXB_ERR];
            rx_idx_reg   <= '0;
          end
        end
        PHYRM_SEND: begin
          if (rx_load) begin
            rx_shift_reg <= buf_data[BYTE_W-1:0];
            rx_err_reg   <= buf_data[RXB_ERR];
            rx_idx_reg   <= '0;
          end else if (rx_idx_reg == LAST_DIBIT) begin
            rx_state_reg <= PHYRM_IDLE;
            rx_idx_reg   <= '0;
          end else begin
            rx_shift_reg <= {2'h0, rx_shift_reg[BYTE_W-1:2]};
            rx_idx_reg   <= rx_idx_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive pins
  // ----------------------------------------------------------------
  logic       sending;       // a byte is in flight
  logic [1:0] dibit_now;     // dibit for this slot

  assign sending   = (rx_state_reg == PHYRM_SEND);
  // bad symbols replace the data so a careless mac drops the frame
  assign dibit_now = rx_err_reg ? ERR_DIBIT : rx_shift_reg[1:0];

  // pins change only on dibit slots, held ten cycles when slow
  always_ff @(posedge clk) begin
    if (!rstn) begin
      receive_dibit_low      <= 1'b0;
      receive_dibit_high     <= 1'b0;
      receive_valid_flag     <= 1'b0;
      receive_error_flag     <= 1'b0;
      carrier_valid_combined <= 1'b0;
    end else if (dibit_en) begin
      receive_valid_flag <= sending;
      receive_dibit_low  <= sending && dibit_now[0];
      receive_dibit_high <= sending && dibit_now[1];
      receive_error_flag <= sending && rx_err_reg;
      // after carrier loss the flag toggles per dibit until drained
      carrier_valid_combined <= rx_carrier ||
                                (sending && rx_idx_reg[0]);
    end
  end

  // ----------------------------------------------------------------
  // transmit dibit assembly
  // ----------------------------------------------------------------
  logic [3:0]        tx_phase_reg;   // slot phase from frame start
  logic [1:0]        tx_idx_reg;     // dibit within byte
  logic [BYTE_W-1:0] tx_acc_reg;     // byte under assembly
  logic              tx_take;        // sample this cycle

  // slot phase restarts with the frame so slow dibits are taken on the first cycle of each slot
  always_ff @(posedge clk) begin
    if (!rstn || !transmit_valid_input || speed_100) begin
      tx_phase_reg <= '0;
    end else if (tx_phase_reg == SLOW_LAST) begin
      tx_phase_reg <= '0;
    end else begin
      tx_phase_reg <= tx_phase_reg + 1'b1;
    end
  end

  assign tx_take = transmit_valid_input &&
                   (speed_100 || tx_phase_reg == 4'h0);

  // shift in dibits low pair first, hand out whole bytes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_idx_reg    <= '0;
      tx_acc_reg    <= '0;
      tx_byte_data  <= '0;
      tx_byte_valid <= 1'b0;
    end else begin
      tx_byte_valid <= 1'b0;
      if (!transmit_valid_input) begin
        tx_idx_reg <= '0; // partial byte dropped
      end else if (tx_take) begin
        tx_acc_reg <= {transmit_dibit_high, transmit_dibit_low,
                       tx_acc_reg[BYTE_W-1:2]};
        tx_idx_reg <= tx_idx_reg + 1'b1;
        if (tx_idx_reg == LAST_DIBIT) begin
          tx_byte_data  <= {transmit_dibit_high, transmit_dibit_low,
                            tx_acc_reg[BYTE_W-1:2]};
          tx_byte_valid <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // link and activity indicator
  // ----------------------------------------------------------------
  logic [31:0] blink_cnt_reg;   // blink half period count
  logic        blink_reg;       // blink phase
  logic        act_reg;         // activity seen this period
  logic        act_hold_reg;    // activity of last period
  logic        led_s1_reg;      // pin sync stage 1
  logic        led_s2_reg;      // pin sync stage 2
  logic        led_s3_reg;      // pin sync stage 3

  // blink timer and activity stretch
  always_ff @(posedge clk) begin
    if (!rstn) begin
      blink_cnt_reg <= '0;
      blink_reg     <= 1'b0;
      act_reg       <= 1'b0;
      act_hold_reg  <= 1'b0;
    end else if (blink_cnt_reg == 32'(BLINK_CYCLES - 1)) begin
      blink_cnt_reg <= '0;
      blink_reg     <= !blink_reg;
      act_hold_reg  <= act_reg || sending || transmit_valid_input;
      act_reg       <= 1'b0;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 1'b1;
      act_reg       <= act_reg || sending || transmit_valid_input;
    end
  end

  // indicator pin drive or general purpose use
  always_ff @(posedge clk) begin
    if (!rstn) begin
      link_activity_indicator      <= 1'b0;
      link_activity_indicator_oe_n <= 1'b0;
    end else if (led_gpio_enable) begin
      link_activity_indicator      <= led_gpio_drive_out;
      link_activity_indicator_oe_n <= led_gpio_dir_in;
    end else begin
      link_activity_indicator      <= link_up &&
                                      (!act_hold_reg || blink_reg);
      link_activity_indicator_oe_n <= 1'b0;
    end
  end

  // pin level read back through a three stage sync
  always_ff @(posedge clk) begin
    if (!rstn) begin
      led_s1_reg     <= 1'b0;
      led_s2_reg     <= 1'b0;
      led_s3_reg     <= 1'b0;
      led_gpio_level <= 1'b0;
    end else begin
      led_s1_reg <= link_activity_indicator_in;
      led_s2_reg <= led_s1_reg;
      led_s3_reg <= led_s2_reg;
      if (led_s2_reg == led_s3_reg) begin
        led_gpio_level <= led_s3_reg;
      end
    end
  end

endmodule // phyrm_pin_interface
`default_nettype wire

/* testbench/phyrm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module phyrm_monitor
  import phyrm_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic speed_100,
  input wire logic link_up,
  input wire logic led_gpio_enable,
  input wire logic led_gpio_dir_in,
  input wire logic led_gpio_drive_out,
  input wire logic rx_carrier,
  input wire logic transmit_valid_input,
  input wire logic receive_dibit_low,
  input wire logic receive_dibit_high,
  input wire logic receive_valid_flag,
  input wire logic carrier_valid_combined,
  input wire logic receive_error_flag,
  input wire logic tx_byte_valid,
  input wire logic master_mode,
  input wire logic master_clock_output,
  input wire logic master_clock_output_oe_n,
  input wire logic link_activity_indicator,
  input wire logic link_activity_indicator_oe_n
);
  // ----------------------------------------------------------------
  // clocking for every check
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // outputs quiet on the first edge out of reset
  rst_quiet_a: assert property ($rose(rstn) |->
    !receive_valid_flag && !tx_byte_valid && master_clock_output_oe_n)
    else $error("outputs active right after reset");
  // clock pin toggles and is driven once master mode settles
  clk_toggle_a: assert property (master_mode && $past(master_mode, 2) |->
    master_clock_output != $past(master_clock_output)
    && !master_clock_output_oe_n)
    else $error("master clock output not toggling");
  // bad byte shows as the corrupt pattern inside a frame
  err_dibit_a: assert property (receive_error_flag |->
    receive_valid_flag
    && {receive_dibit_high, receive_dibit_low} == ERR_DIBIT)
    else $error("error dibit not corrupted");
  // carrier keeps the merged flag up
  merge_flag_a: assert property (
    receive_valid_flag && $past(rx_carrier) |-> carrier_valid_combined)
    else $error("merged flag low with carrier");
  // slow rate holds the first dibit ten cycles
  slow_hold_a: assert property (
    $rose(receive_valid_flag) && !speed_100 |=>
    ($stable({receive_dibit_high, receive_dibit_low}))[*8] ##1
    $stable({receive_dibit_high, receive_dibit_low}))
    else $error("slow dibit changed early");
  // four fast dibits give a byte on the fifth edge
  tx_latency_a: assert property (
    $rose(transmit_valid_input) && speed_100 |-> ##4 tx_byte_valid)
    else $error("transmit byte late");
  // byte strobe lasts one cycle
  tx_pulse_a: assert property (tx_byte_valid && speed_100 |=>
    !tx_byte_valid)
    else $error("transmit strobe too long");
  // general purpose mode follows its controls
  gpio_out_a: assert property (
    led_gpio_enable && $past(led_gpio_enable) |->
    link_activity_indicator == $past(led_gpio_drive_out)
    && link_activity_indicator_oe_n == $past(led_gpio_dir_in))
    else $error("gpio pin wrong");
  // no link means indicator dark
  led_link_a: assert property (
    !led_gpio_enable && !$past(led_gpio_enable) && !$past(link_up)
    |-> !link_activity_indicator)
    else $error("indicator lit without link");
endmodule // phyrm_monitor

bind phyrm_pin_interface phyrm_monitor u_mon (.clk, .rstn, .speed_100,
  .link_up, .led_gpio_enable, .led_gpio_dir_in, .led_gpio_drive_out,
  .rx_carrier, .transmit_valid_input, .receive_dibit_low,
  .receive_dibit_high, .receive_valid_flag, .carrier_valid_combined,
  .receive_error_flag, .tx_byte_valid, .master_mode, .master_clock_output,
  .master_clock_output_oe_n, .link_activity_indicator,
  .link_activity_indicator_oe_n);
`default_nettype wire

/* testbench/phyrm_mac_model.sv */
`timescale 1ns/1ps
`default_nettype none
module phyrm_mac_model (
  input  wire logic clk,
  input  wire logic speed_100,
  output logic      transmit_dibit_low,
  output logic      transmit_dibit_high,
  output logic      transmit_valid_input,
  input  wire logic receive_dibit_low,
  input  wire logic receive_dibit_high,
  input  wire logic receive_valid_flag,
  input  wire logic receive_error_flag
);
  logic [2:0] rx_q[$];  // captured {error, high, low} per cycle

  // pins idle low, as the pull-downs leave them
  initial begin
    {transmit_dibit_high, transmit_dibit_low} = 2'h0;
    transmit_valid_input = 1'b0;
  end

  // capture every cycle the phy marks as valid
  always @(posedge clk) begin
    if (receive_valid_flag) begin
      rx_q.push_back({receive_error_flag, receive_dibit_high,
                      receive_dibit_low});
    end
  end

  // one byte, low pair first, held per rate
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 4; i++) begin
      repeat (speed_100 ? 1 : 10) begin
        @(negedge clk);
        {transmit_dibit_high, transmit_dibit_low} = b[2*i +: 2];
        transmit_valid_input = 1'b1;
      end
    end
  endtask

  // release the transmit pins
  task automatic idle;
    @(negedge clk);
    transmit_valid_input = 1'b0;
    {transmit_dibit_high, transmit_dibit_low} = 2'h0;
  endtask
endmodule // phyrm_mac_model
`default_nettype wire

/* testbench/test_phy_rmii_pin_interface.sv */
`timescale 1ns/1ps
`default_nettype none
module test_phy_rmii_pin_interface
  import phyrm_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic       clk, rstn, link_up, speed_100, rx_carrier;
  logic [1:0] strap_pins_in;
  logic       led_gpio_enable, led_gpio_dir_in, led_gpio_drive_out;
  logic       link_activity_indicator_in, link_activity_indicator;
  logic       link_activity_indicator_oe_n, led_gpio_level, master_mode;
  logic       master_clock_output_oe_n, rx_byte_error, rx_byte_valid;
  logic [7:0] rx_byte_data, tx_byte_data;
  logic       rx_byte_ready, tx_byte_valid, receive_error_flag;
  logic       receive_dibit_low, receive_dibit_high, receive_valid_flag;
  logic       carrier_valid_combined, transmit_valid_input;
  logic       transmit_dibit_low, transmit_dibit_high;
  int         n_mismatch, tests_run;

  phyrm_pin_interface #(.BLINK_CYCLES(8)) dut (.clk, .rstn,
    .strap_pins_in, .link_up, .speed_100, .led_gpio_enable,
    .led_gpio_dir_in, .led_gpio_drive_out, .link_activity_indicator_in,
    .link_activity_indicator, .link_activity_indicator_oe_n,
    .led_gpio_level, .master_mode, .master_clock_output(),
    .master_clock_output_oe_n, .rx_carrier, .rx_byte_data, .rx_byte_error,
    .rx_byte_valid, .rx_byte_ready, .receive_dibit_low, .receive_dibit_high,
    .receive_valid_flag, .carrier_valid_combined, .receive_error_flag,
    .transmit_dibit_low, .transmit_dibit_high, .transmit_valid_input,
    .tx_byte_data, .tx_byte_valid);

  phyrm_mac_model mac (.clk, .speed_100, .transmit_dibit_low,
    .transmit_dibit_high, .transmit_valid_input, .receive_dibit_low,
    .receive_dibit_high, .receive_valid_flag, .receive_error_flag);

  // 40 ns reference clock
  always #20 clk = ~clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [8:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // reset low with straps held, then latched mode judged
  task automatic reset_dut(input logic [1:0] straps, input int len);
    @(negedge clk);
    rstn = 1'b0;
    strap_pins_in = straps;
    repeat (len) @(negedge clk);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    check("master", 9'(master_mode), 9'(straps[0]));
    check("oe", {8'h0, master_clock_output_oe_n}, 9'(!straps[0]));
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // four back-to-back bytes, third one bad, at the given rate
  task automatic rx_burst(input logic spd);
    logic [8:0] src[4] = '{9'h0B4, 9'h0A5, 9'h13C, 9'h0FF};
    int step, n;
    step = spd ? 1 : 10;
    mac.rx_q.delete();
    @(negedge clk);
    speed_100 = spd;
    rx_carrier = 1'b1;
    foreach (src[i]) begin
      {rx_byte_error, rx_byte_data} = src[i];
      rx_byte_valid = 1'b1;
      n = 0;
      do @(posedge clk); while (rx_byte_ready !== 1'b1 && ++n < 60);
      if (n == 60) n_mismatch++;
      @(negedge clk);
    end
    rx_byte_valid = 1'b0;
    rx_carrier = 1'b0;
    repeat (spd ? 20 : 200) @(negedge clk);
    check("merged flag", 9'(carrier_valid_combined), 9'h000);
    check("rx count", 9'(mac.rx_q.size()), 9'(16 * step));
    for (int i = 0; i < 16; i++) begin
      for (int j = 0; j < step; j++) begin
        check("rx dibit", {6'h0, mac.rx_q[i*step+j]}, {6'h0, src[i/4][8],
          src[i/4][8] ? ERR_DIBIT : src[i/4][2*(i%4) +: 2]});
      end
    end
  endtask

  // two bytes from the mac, each checked on its strobe
  task automatic tx_run(input logic spd);
    logic [7:0] exp[2] = '{8'hB4, 8'h5A};
    int n;
    @(negedge clk);
    speed_100 = spd;
    fork
      begin
        mac.send(exp[0]);
        mac.send(exp[1]);
        mac.idle();
      end
      foreach (exp[i]) begin
        n = 0;
        do @(posedge clk); while (tx_byte_valid !== 1'b1 && ++n < 100);
        check("tx strobe", {8'h0, tx_byte_valid}, 9'h001);
        check("tx byte", {1'b0, tx_byte_data}, {1'b0, exp[i]});
      end
    join
  endtask

  // gpio mode, steady link light, blinking on traffic
  task automatic led_run;
    int hi, lo;
    @(negedge clk);
    {led_gpio_enable, led_gpio_dir_in, led_gpio_drive_out} = 3'h5;
    repeat (2) @(negedge clk);
    check("gpio pin", {8'h0, link_activity_indicator}, 9'h001);
    check("gpio oe", {8'h0, link_activity_indicator_oe_n}, 9'h000);
    led_gpio_dir_in = 1'b1;
    link_activity_indicator_in = 1'b1;
    repeat (5) @(negedge clk);
    check("gpio oe", {8'h0, link_activity_indicator_oe_n}, 9'h001);
    check("gpio level", {8'h0, led_gpio_level}, 9'h001);
    led_gpio_enable = 1'b0;
    link_up = 1'b1;
    repeat (30) @(negedge clk);
    check("led steady", {8'h0, link_activity_indicator}, 9'h001);
    hi = 0;
    lo = 0;
    speed_100 = 1'b0;
    fork
      begin
        mac.send(8'h3C);
        mac.send(8'hC3);
        mac.idle();
      end
      repeat (70) begin
        @(negedge clk);
        if (link_activity_indicator) hi++;
        else lo++;
      end
    join
    check("led blink", {8'h0, hi > 0 && lo > 0}, 9'h001);
    link_up = 1'b0;
    repeat (3) @(negedge clk);
    check("led off", {8'h0, link_activity_indicator}, 9'h000);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {clk, rstn, link_up, speed_100, rx_carrier, strap_pins_in} = '0;
    {led_gpio_enable, led_gpio_dir_in, led_gpio_drive_out} = 3'h0;
    {link_activity_indicator_in, rx_byte_error, rx_byte_valid} = 3'h0;
    {rx_byte_data, n_mismatch, tests_run} = '0;
    reset_dut(2'h1, 16);
    reset_dut(2'h0, 25);
    rx_burst(1'b1);
    rx_burst(1'b0);
    tx_run(1'b1);
    tx_run(1'b0);
    led_run();
    stop_test();
  end

  initial begin
    #200_000;
    n_mismatch++;
    stop_test();
  end
endmodule // test_phy_rmii_pin_interface
`default_nettype wire
